// >>> gpc_pkg.sv
// shared constants and types for the 8-bit general purpose port block
package gpc_pkg;
    localparam int GPC_PW = 8;
    localparam int GPC_AW = 8;
    // register byte addresses on the bus
    localparam logic [7:0] GPC_OFF_LATCH = 8'h00;
    localparam logic [7:0] GPC_OFF_PIN = 8'h04;
    localparam logic [7:0] GPC_OFF_DIR = 8'h08;
    localparam logic [7:0] GPC_OFF_ANA = 8'h0C;
    localparam logic [7:0] GPC_OFF_PU = 8'h10;
    localparam logic [7:0] GPC_OFF_LVL = 8'h14;
    localparam logic [7:0] GPC_OFF_OPT = 8'h18;
    // reset values, before the package mask is applied
    localparam logic [7:0] GPC_RST_LATCH = 8'h00;
    localparam logic [7:0] GPC_RST_DIR = 8'hFF;
    localparam logic [7:0] GPC_RST_ANA = 8'hFF;
    localparam logic [7:0] GPC_RST_PU = 8'hFF;
    localparam logic [7:0] GPC_RST_LVL = 8'h04;
    localparam logic GPC_RST_GPD = 1'b1;
    localparam int GPC_OPT_GPD_BIT = 0;
    // implemented bit masks per package variant, plus the analog select bit mask used by both
    localparam logic [7:0] GPC_MASK_LARGE = 8'hFF;
    localparam logic [7:0] GPC_MASK_SMALL = 8'h3F;
    localparam logic [7:0] GPC_MASK_ANA = 8'hCF;
    localparam logic [1:0] GPC_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] GPC_HTRANS_SEQ = 2'h3;
    localparam logic GPC_HRESP_OKAY = 1'b0;
    localparam logic [31:0] GPC_ZERO_WORD = 32'h0000_0000;
    typedef enum logic [1:0] {
        GPC_ST_IDLE,
        GPC_ST_WRITE,
        GPC_ST_RD_WAIT,
        GPC_ST_RD_DONE
    } gpc_bus_e;
endpackage

// >>> gpc_sync.sv
// two-stage synchroniser for the sampled pin levels
module gpc_sync
    import gpc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [GPC_PW-1:0] async_in,
    output logic [GPC_PW-1:0] sync_out
);
    logic [GPC_PW-1:0] stage1;
    logic [GPC_PW-1:0] next_stage1;
    logic [GPC_PW-1:0] next_sync_out;

    always_comb begin
        next_stage1 = async_in;
        next_sync_out = stage1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage1 <= 8'h00;
            sync_out <= 8'h00;
        end else begin
            stage1 <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule // gpc_sync

// >>> gpc_pin_cell.sv
// pad control for one port pin: drive, pull-up, threshold and input gating
module gpc_pin_cell (
    input wire logic direction_bit,
    input wire logic latch_bit,
    input wire logic analog_select_bit,
    input wire logic pullup_bit,
    input wire logic global_pullup_disable,
    input wire logic level_bit,
    input wire logic pad_in_st,
    input wire logic pad_in_ttl,
    output logic pad_out,
    output logic pad_oe,
    output logic pullup_on,
    output logic dig_in
);
    always_comb begin
        // analog select never blocks the output driver
        pad_oe = ~direction_bit;
        pad_out = latch_bit;
        pullup_on = pullup_bit & ~global_pullup_disable
                    & direction_bit;
        // buffer off in analog mode, so reads see zero
        if (analog_select_bit) begin
            dig_in = 1'b0;
        end else begin
            dig_in = level_bit ? pad_in_st : pad_in_ttl;
        end
    end
endmodule // gpc_pin_cell

// >>> gpc_port.sv
// 8-bit general purpose port with its registers on an AHB-Lite slave
//
// Functional notes
// - software writes to the pin data address land in the output latch
// - reading pin data returns sampled pin levels, not the latch
// - small package: bits 7:6 of all registers absent, read zero
// - analog select clear keeps pin digital; bits exist for 7, 6, 3..0
// - analog select set makes analog input, digital input buffer off
// - pull-up enable bit one turns pull-up on, zero turns it off
// - global pull-up disable set keeps every pull-up off
// - pin configured as output has its pull-up forced off
// - reset loads analog select and pull-up ones, level select 0x04
// - level bit one picks Schmitt threshold, zero picks TTL threshold
// - digital reads of an analog selected pin return zero
// - direction one tri-states the pin, zero drives the latch value
// - analog selected output pin still drives its latch value
//
// The placing of the registers and the AHB-Lite register port were decided locally.
module gpc_port
    import gpc_pkg::*;
#(
    parameter bit LARGE_PACKAGE = 1'b1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [GPC_PW-1:0] pad_in_st,
    input wire logic [GPC_PW-1:0] pad_in_ttl,
    output logic [GPC_PW-1:0] pad_out,
    output logic [GPC_PW-1:0] pad_oe,
    output logic [GPC_PW-1:0] pullup_on
);
    // per-variant masks, constants so reset values stay constant
    localparam logic [7:0] IMPL_MASK =
        LARGE_PACKAGE ? GPC_MASK_LARGE : GPC_MASK_SMALL;
    localparam logic [7:0] ANA_MASK = GPC_MASK_ANA & IMPL_MASK;

    // bits a write may change at a given register address; OPT is written from hwdata, not through this mask
    function automatic logic [7:0] write_mask(input logic [7:0] off);
        case (off)
            GPC_OFF_LATCH, GPC_OFF_PIN, GPC_OFF_DIR,
            GPC_OFF_PU, GPC_OFF_LVL: write_mask = IMPL_MASK;
            GPC_OFF_ANA: write_mask = ANA_MASK;
            default: write_mask = 8'h00;
        endcase
    endfunction

    // bus state
    gpc_bus_e state;
    gpc_bus_e next_state;
    logic [7:0] addr_q;
    logic [7:0] next_addr_q;
    logic write_q;
    logic next_write_q;
    logic [31:0] next_hrdata;
    logic take;

    // register state
    logic [7:0] port_output_latch;
    logic [7:0] port_direction;
    logic [7:0] analog_select;
    logic [7:0] pullup_enable;
    logic [7:0] input_level_select;
    logic global_pullup_disable;
    logic [7:0] next_latch;
    logic [7:0] next_dir;
    logic [7:0] next_ana;
    logic [7:0] next_pu;
    logic [7:0] next_lvl;
    logic next_gpd;

    logic [7:0] dig_in;
    logic [7:0] pin_sync;
    logic [7:0] port_pin_data;
    logic wr_en;
    logic [7:0] wmask;
    logic [7:0] wbyte;

    // only whole-word transfers are expected; hsize is not checked
    assign take = hsel & hready & (htrans == GPC_HTRANS_NONSEQ
                                   || htrans == GPC_HTRANS_SEQ);
    assign hresp = GPC_HRESP_OKAY;
    // one wait state on reads so read data sees any write just before it
    assign hreadyout = (state != GPC_ST_RD_WAIT);

    always_comb begin
        next_state = state;
        next_addr_q = addr_q;
        next_write_q = write_q;
        next_hrdata = hrdata;
        case (state)
            GPC_ST_RD_WAIT: begin
                next_state = GPC_ST_RD_DONE;
                case (addr_q)
                    GPC_OFF_LATCH: next_hrdata = {24'h000000, port_output_latch};
                    GPC_OFF_PIN: next_hrdata = {24'h000000, port_pin_data};
                    GPC_OFF_DIR: next_hrdata = {24'h000000, port_direction};
                    GPC_OFF_ANA: next_hrdata = {24'h000000, analog_select};
                    GPC_OFF_PU: next_hrdata = {24'h000000, pullup_enable};
                    GPC_OFF_LVL: next_hrdata = {24'h000000, input_level_select};
                    GPC_OFF_OPT: next_hrdata = {31'h0,
                                                global_pullup_disable};
                    default: next_hrdata = GPC_ZERO_WORD;
                endcase
            end
            GPC_ST_IDLE, GPC_ST_WRITE, GPC_ST_RD_DONE: begin
                if (take) begin
                    next_addr_q = haddr[GPC_AW-1:0];
                    next_write_q = hwrite;
                    next_state = hwrite ? GPC_ST_WRITE : GPC_ST_RD_WAIT;
                end else begin
                    next_state = GPC_ST_IDLE;
                end
            end
            default: next_state = GPC_ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= GPC_ST_IDLE;
            addr_q <= 8'h00;
            write_q <= 1'b0;
            hrdata <= GPC_ZERO_WORD;
        end else begin
            state <= next_state;
            addr_q <= next_addr_q;
            write_q <= next_write_q;
            hrdata <= next_hrdata;
        end
    end

    // write data phase: register updates at the closing edge
    assign wr_en = (state == GPC_ST_WRITE);
    assign wmask = write_mask(addr_q);
    assign wbyte = hwdata[7:0] & wmask;

    always_comb begin
        next_latch = port_output_latch;
        next_dir = port_direction;
        next_ana = analog_select;
        next_pu = pullup_enable;
        next_lvl = input_level_select;
        next_gpd = global_pullup_disable;
        if (wr_en) begin
            case (addr_q)
                // pin data writes go to the latch, no separate store
                GPC_OFF_LATCH, GPC_OFF_PIN: next_latch = wbyte;
                GPC_OFF_DIR: next_dir = wbyte;
                GPC_OFF_ANA: next_ana = wbyte;
                GPC_OFF_PU: next_pu = wbyte;
                GPC_OFF_LVL: next_lvl = wbyte;
                GPC_OFF_OPT: next_gpd = hwdata[GPC_OPT_GPD_BIT];
                default: next_latch = port_output_latch;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_output_latch <= GPC_RST_LATCH;
            port_direction <= GPC_RST_DIR & IMPL_MASK;
            analog_select <= GPC_RST_ANA & ANA_MASK;
            pullup_enable <= GPC_RST_PU & IMPL_MASK;
            input_level_select <= GPC_RST_LVL & IMPL_MASK;
            // pull-ups stay off after reset until software allows them
            global_pullup_disable <= GPC_RST_GPD;
        end else begin
            port_output_latch <= next_latch;
            port_direction <= next_dir;
            analog_select <= next_ana;
            pullup_enable <= next_pu;
            input_level_select <= next_lvl;
            global_pullup_disable <= next_gpd;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < GPC_PW; gi++) begin : g_pin
            gpc_pin_cell u_cell (
                .direction_bit(port_direction[gi] | ~IMPL_MASK[gi]),
                .latch_bit(port_output_latch[gi]),
                .analog_select_bit(analog_select[gi]),
                .pullup_bit(pullup_enable[gi]),
                .global_pullup_disable(global_pullup_disable),
                .level_bit(input_level_select[gi]),
                .pad_in_st(pad_in_st[gi]),
                .pad_in_ttl(pad_in_ttl[gi]),
                .pad_out(pad_out[gi]),
                .pad_oe(pad_oe[gi]),
                .pullup_on(pullup_on[gi]),
                .dig_in(dig_in[gi])
            );
        end
    endgenerate

    gpc_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(dig_in),
        .sync_out(pin_sync)
    );

    // analog pins read zero at once, not after the sync delay
    assign port_pin_data = pin_sync & ~analog_select
                           & IMPL_MASK;

    a_latch_write: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_en && (addr_q == GPC_OFF_PIN || addr_q == GPC_OFF_LATCH))
        |=> port_output_latch == ($past(hwdata[7:0]) & IMPL_MASK))
        else $error("latch not loaded by data write");

    a_pin_read: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == GPC_ST_RD_WAIT && addr_q == GPC_OFF_PIN)
        |=> hreadyout && hrdata[7:0] == $past(port_pin_data))
        else $error("pin read returned wrong value");

    a_unimpl_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        ((port_output_latch | port_direction | pullup_enable
          | input_level_select | analog_select) & ~IMPL_MASK) == 8'h00
        && (analog_select & ~ANA_MASK) == 8'h00)
        else $error("unimplemented bit set");

    a_analog_read: assert property (@(posedge hclk) disable iff (!hresetn)
        (port_pin_data & analog_select) == 8'h00)
        else $error("analog pin read as one");

    a_pullup_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        pullup_on == (pullup_enable & port_direction & IMPL_MASK
                      & {GPC_PW{~global_pullup_disable}}))
        else $error("pull-up state wrong");

    a_pullup_output: assert property (@(posedge hclk) disable iff (!hresetn)
        (pullup_on & pad_oe) == 8'h00)
        else $error("pull-up on while driving");

    a_pin_drive: assert property (@(posedge hclk) disable iff (!hresetn)
        pad_oe == (~port_direction & IMPL_MASK)
        && ((pad_out ^ port_output_latch) & pad_oe) == 8'h00)
        else $error("pin drive wrong");

    // first edge after release still sees reset: the flops held zero there
    a_sync_delay: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn |-> ##2 pin_sync == $past(dig_in, 2))
        else $error("pin sample not two edges late");

    a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    a_level_select: assert property (@(posedge hclk) disable iff (!hresetn)
        ((dig_in ^ pad_in_st) & input_level_select & ~analog_select) == 8'h00)
        else $error("schmitt input not used");

    a_reset_vals: assert property (@(posedge hclk)
        $rose(hresetn) |-> analog_select == (GPC_RST_ANA & ANA_MASK)
        && pullup_enable == (GPC_RST_PU & IMPL_MASK)
        && input_level_select == (GPC_RST_LVL & IMPL_MASK))
        else $error("reset value wrong");
endmodule // gpc_port

// >>> gpc_board.sv
// board model that drives the port pins from outside the device
module gpc_board
    import gpc_pkg::*;
(
    input wire logic hclk,
    input wire logic [GPC_PW-1:0] pad_out,
    input wire logic [GPC_PW-1:0] pad_oe,
    input wire logic [GPC_PW-1:0] pullup_on,
    input wire logic [GPC_PW-1:0] ext_drive,
    input wire logic [GPC_PW-1:0] ext_st,
    input wire logic [GPC_PW-1:0] ext_ttl,
    output logic [GPC_PW-1:0] pad_in_st,
    output logic [GPC_PW-1:0] pad_in_ttl
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [GPC_PW-1:0] drift = 8'h55;
    // a floating pin must not look like a stable level
    always @(posedge hclk) drift <= ~drift;
    always_comb begin
        for (int i = 0; i < GPC_PW; i++) begin
            if (pad_oe[i]) begin
                pad_in_st[i] = pad_out[i];
                pad_in_ttl[i] = pad_out[i];
            end else if (ext_drive[i]) begin
                pad_in_st[i] = ext_st[i];
                pad_in_ttl[i] = ext_ttl[i];
            end else if (pullup_on[i]) begin
                pad_in_st[i] = 1'b1;
                pad_in_ttl[i] = 1'b1;
            end else begin
                pad_in_st[i] = drift[i];
                pad_in_ttl[i] = ~drift[i];
            end
        end
    end
endmodule // gpc_board

// >>> gpc_port_bench.sv
// self-checking bench for the port block, both package variants
module gpc_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import gpc_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} gpc_row_s;
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, hreadyout, hreadyout_s, hresp, hresp_s;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, hrdata_s, rd, rd_s;
    logic [7:0] pad_out, pad_oe, pullup_on, pin_st, pin_ttl;
    logic [7:0] pad_out_s, pad_oe_s, pullup_on_s, pin_st_s, pin_ttl_s;
    logic [7:0] ext_drive, ext_st, ext_ttl;
    int fails = 0;
    int checked = 0;
    gpc_row_s rows [10] = '{
        '{GPC_OFF_LATCH, 32'hFF, 32'hFF}, '{GPC_OFF_LATCH, 32'h00, 32'h00},
        '{GPC_OFF_DIR, 32'h0F, 32'h0F}, '{GPC_OFF_ANA, 32'hFF, 32'hCF},
        '{GPC_OFF_ANA, 32'h30, 32'h00}, '{GPC_OFF_PU, 32'h5A, 32'h5A},
        '{GPC_OFF_LVL, 32'h3C, 32'h3C}, '{GPC_OFF_OPT, 32'hFF, 32'h01},
        '{GPC_OFF_OPT, 32'h00, 32'h00}, '{8'h1C, 32'hFF, 32'h00}};
    gpc_row_s rst_rows [6] = '{
        '{GPC_OFF_LATCH, 0, 32'h00}, '{GPC_OFF_DIR, 0, 32'hFF},
        '{GPC_OFF_ANA, 0, 32'hCF}, '{GPC_OFF_PU, 0, 32'hFF},
        '{GPC_OFF_LVL, 0, 32'h04}, '{GPC_OFF_OPT, 0, 32'h01}};

    always #20 hclk = ~hclk;

    gpc_port #(.LARGE_PACKAGE(1'b1)) uut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pad_in_st(pin_st), .pad_in_ttl(pin_ttl), .pad_out(pad_out),
        .pad_oe(pad_oe), .pullup_on(pullup_on));
    gpc_port #(.LARGE_PACKAGE(1'b0)) uut_small (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout_s), .hresp(hresp_s), .hrdata(hrdata_s),
        .pad_in_st(pin_st_s), .pad_in_ttl(pin_ttl_s), .pad_out(pad_out_s),
        .pad_oe(pad_oe_s), .pullup_on(pullup_on_s));
    gpc_board board (.hclk(hclk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pullup_on(pullup_on), .ext_drive(ext_drive), .ext_st(ext_st),
        .ext_ttl(ext_ttl), .pad_in_st(pin_st), .pad_in_ttl(pin_ttl));
    gpc_board board_small (.hclk(hclk), .pad_out(pad_out_s),
        .pad_oe(pad_oe_s), .pullup_on(pullup_on_s), .ext_drive(ext_drive),
        .ext_st(ext_st), .ext_ttl(ext_ttl), .pad_in_st(pin_st_s),
        .pad_in_ttl(pin_ttl_s));

    task automatic finish_test();
        if (fails == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] s,
        input logic [31:0] e);
        checked++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask

    // ready is looked at mid-cycle, so the edge that follows is the one
    // on which it is sampled high
    task automatic wait_rdy();
        int n;
        n = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                fails++;
                finish_test();
            end
            @(negedge hclk);
        end
        rd = hrdata;
        rd_s = hrdata_s;
        chk("hresp", {31'h0, hresp}, {31'h0, GPC_HRESP_OKAY});
        chk("hresp small", {31'h0, hresp_s}, 32'h0);
        chk("hreadyout small", {31'h0, hreadyout_s}, 32'h1);
        @(posedge hclk);
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= GPC_HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask

    task automatic rd_pins(input logic [31:0] e);
        repeat (2) @(posedge hclk);
        bus(1'b0, GPC_OFF_PIN, 32'h0);
        chk("pin data", rd, e);
        chk("pin data small", rd_s, e & 32'h3F);
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        ext_drive = 8'h00;
        ext_st = 8'h00;
        ext_ttl = 8'h00;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].d);
            bus(1'b0, rows[i].a, 32'h0);
            chk("register", rd, rows[i].e);
            chk("register small", rd_s, rows[i].e & 32'h3F);
        end
        // pin data address writes the latch
        bus(1'b1, GPC_OFF_PIN, 32'hA5);
        bus(1'b0, GPC_OFF_LATCH, 32'h0);
        chk("latch", rd, 32'hA5);
        chk("latch small", rd_s, 32'h25);
        chk("pad_out", pad_out, 32'hA5);
        chk("pad_oe", pad_oe, 32'hF0);
        chk("pad_oe small", pad_oe_s, 32'h30);
        chk("pad_out small", pad_out_s, 32'h25);
        // inputs: threshold per bit, then analog gating
        bus(1'b1, GPC_OFF_DIR, 32'hFF);
        bus(1'b1, GPC_OFF_LVL, 32'h0F);
        ext_drive <= 8'hFF;
        ext_st <= 8'hFF;
        ext_ttl <= 8'h00;
        rd_pins(32'h0F);
        bus(1'b1, GPC_OFF_ANA, 32'h0F);
        rd_pins(32'h00);
        // pull-ups: global gate and direction override
        bus(1'b1, GPC_OFF_PU, 32'hFF);
        bus(1'b1, GPC_OFF_OPT, 32'h00);
        bus(1'b1, GPC_OFF_DIR, 32'hF0);
        @(negedge hclk);
        chk("pullup_on", pullup_on, 32'hF0);
        chk("pullup_on small", pullup_on_s, 32'h30);
        bus(1'b1, GPC_OFF_PU, 32'h0F);
        @(negedge hclk);
        chk("pullup_on", pullup_on, 32'h00);
        bus(1'b1, GPC_OFF_PU, 32'hFF);
        bus(1'b1, GPC_OFF_OPT, 32'h01);
        @(negedge hclk);
        chk("pullup_on", pullup_on, 32'h00);
        // outputs keep driving while analog is selected
        bus(1'b1, GPC_OFF_DIR, 32'h00);
        bus(1'b1, GPC_OFF_ANA, 32'hFF);
        bus(1'b1, GPC_OFF_LATCH, 32'h5A);
        ext_drive <= 8'h00;
        @(negedge hclk);
        chk("pad_oe", pad_oe, 32'hFF);
        chk("pad_out", pad_out, 32'h5A);
        rd_pins(32'h10);
        // reset in mid-run
        @(posedge hclk);
        hresetn <= 1'b0;
        @(negedge hclk);
        chk("pad_oe in reset", pad_oe, 32'h00);
        chk("pullup_on in reset", pullup_on, 32'h00);
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rst_rows[i]) begin
            bus(1'b0, rst_rows[i].a, 32'h0);
            chk("reset value", rd, rst_rows[i].e);
            chk("reset small", rd_s, rst_rows[i].e & 32'h3F);
        end
        finish_test();
    end
endmodule // gpc_port_bench
